// ==== core/brake_seq.sv ====
// holding-brake sequencer with apb registers and digital output mapping
// assumes enable, fault and speed come from pins; apb from core-clock logic
// Operation
// - fault always gives free stop, drive removed
// - brake only on outputs coded 141, polarity set
// - instructions accepted after release delay, default 250
// - static: energized for delay after brake off
// - rotating: configurable speed threshold for brake off
// - rotating: max delay enable off to brake
// - no brake output assigned: settings ignored
// - below 20 rpm static, else rotating
// - static stop: brake off now, power later
// - rotating stop follows rotating sequence only
// - assignment applies on restart, delays immediately
// - rotating brake off at threshold or timeout
// - rotating: energized 50 ms after brake off
`timescale 1ns/1ps
module brake_seq
  import brake_seq_pkg::*;
#(
  parameter int unsigned P_TICK_CYCLES = TICK_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_servo_enable,
  input wire logic i_fault,
  input wire logic [15:0] i_motor_speed_rpm,
  output logic [NUM_DO-1:0] o_brake_release_out,
  output logic o_motor_energize,
  output logic o_instr_accept
);
  function automatic logic is_brake(input logic [7:0] code);
    return code == BRAKE_FUNC_CODE;
  endfunction

  function automatic logic [9:0] clamp10(input logic [31:0] v, input logic [9:0] lo,
                                         input logic [9:0] hi);
    if (v < 32'(lo)) begin
      return lo;
    end else if (v > 32'(hi)) begin
      return hi;
    end
    return v[9:0];
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == DO_FUNC_OFF || a == DO_LOGIC_OFF || a == ACCEPT_DLY_OFF ||
           a == STATIC_DLY_OFF || a == SPEED_LIM_OFF || a == ROT_DLY_OFF ||
           a == APPLY_OFF || a == STATUS_OFF;
  endfunction

  ms_timer_if tm ();

  ms_timer #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_timer (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .tm(tm)
  );

  // pin synchronisers; speed is sampled twice, a torn word lasts one cycle only
  logic en_m_r, en_s_r, fault_m_r, fault_s_r;
  logic [15:0] spd_m_r, spd_s_r;
  always_ff @(posedge i_core_clk) begin
    en_m_r <= i_servo_enable;
    en_s_r <= en_m_r;
    fault_m_r <= i_fault;
    fault_s_r <= fault_m_r;
    spd_m_r <= i_motor_speed_rpm;
    spd_s_r <= spd_m_r;
  end

  // registers
  logic [31:0] pend_func_r, act_func_r;
  logic [3:0] pend_logic_r, act_logic_r;
  logic [9:0] accept_dly_r, static_dly_r, rot_dly_r;
  logic [15:0] speed_lim_r;
  logic wr_en, apply_pulse;
  seq_state_t state_r, state_nxt;
  logic brake_rel_r;
  logic brake_assigned;
  logic moving;

  assign wr_en = i_psel && i_penable && o_pready && i_pwrite;
  assign apply_pulse = wr_en && i_paddr == APPLY_OFF && i_pwdata[0];
  assign moving = spd_s_r >= STATIC_SPEED_RPM;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      pend_func_r <= DO_FUNC_RST;
      pend_logic_r <= DO_LOGIC_RST;
    end else if (wr_en && i_paddr == DO_FUNC_OFF) begin
      pend_func_r <= i_pwdata;
    end else if (wr_en && i_paddr == DO_LOGIC_OFF) begin
      pend_logic_r <= i_pwdata[3:0];
    end
  end

  // output assignment only moves into use on the restart command
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      act_func_r <= DO_FUNC_RST;
      act_logic_r <= DO_LOGIC_RST;
    end else if (apply_pulse) begin
      act_func_r <= pend_func_r;
      act_logic_r <= pend_logic_r;
    end
  end

  // timing settings take effect at once, clamped to their ranges
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      accept_dly_r <= ACCEPT_DLY_RST;
      static_dly_r <= STATIC_DLY_RST;
      speed_lim_r <= SPEED_LIM_RST;
      rot_dly_r <= ROT_DLY_RST;
    end else if (wr_en) begin
      if (i_paddr == ACCEPT_DLY_OFF) begin
        accept_dly_r <= clamp10(i_pwdata, 10'h000, ACCEPT_DLY_MAX);
      end
      if (i_paddr == STATIC_DLY_OFF) begin
        static_dly_r <= clamp10(i_pwdata, DLY_MIN, DLY_MAX);
      end
      if (i_paddr == SPEED_LIM_OFF) begin
        speed_lim_r <= (i_pwdata > 32'(SPEED_LIM_MAX)) ? SPEED_LIM_MAX : i_pwdata[15:0];
      end
      if (i_paddr == ROT_DLY_OFF) begin
        rot_dly_r <= clamp10(i_pwdata, DLY_MIN, DLY_MAX);
      end
    end
  end

  always_comb begin
    brake_assigned = 1'b0;
    for (int i = 0; i < NUM_DO; i++) begin
      brake_assigned = brake_assigned | is_brake(act_func_r[8*i +: 8]);
    end
  end

  // apb: one wait state, read data captured on the same edge that pready rises
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else if (i_psel && i_penable && !o_pready) begin
      o_pready <= 1'b1;
      o_pslverr <= !mapped(i_paddr);
      o_prdata <= 32'h0000_0000;
      if (!i_pwrite) begin
        unique case (i_paddr)
          DO_FUNC_OFF: o_prdata <= pend_func_r;
          DO_LOGIC_OFF: o_prdata <= {28'h0000000, pend_logic_r};
          ACCEPT_DLY_OFF: o_prdata <= {22'h000000, accept_dly_r};
          STATIC_DLY_OFF: o_prdata <= {22'h000000, static_dly_r};
          SPEED_LIM_OFF: o_prdata <= {16'h0000, speed_lim_r};
          ROT_DLY_OFF: o_prdata <= {22'h000000, rot_dly_r};
          STATUS_OFF: begin
            o_prdata[ST_STATE_LSB +: 3] <= state_r;
            o_prdata[ST_ASSIGNED_BIT] <= brake_assigned;
            o_prdata[ST_ACCEPT_BIT] <= o_instr_accept;
            o_prdata[ST_ENERGIZED_BIT] <= o_motor_energize;
            o_prdata[ST_RELEASED_BIT] <= brake_rel_r;
            o_prdata[ST_MOVING_BIT] <= moving;
          end
          default: o_prdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // sequencer
  always_comb begin
    state_nxt = state_r;
    tm.load = 1'b0;
    tm.load_ms = 10'h000;
    if (fault_s_r) begin
      state_nxt = S_FAULT;
    end else begin
      unique case (state_r)
        S_OFF, S_FAULT: begin
          if (en_s_r && state_r == S_OFF) begin
            if (!brake_assigned || accept_dly_r == 10'h000) begin
              state_nxt = S_RUN;
            end else begin
              state_nxt = S_RELEASE_WAIT;
              tm.load = 1'b1;
              tm.load_ms = accept_dly_r;
            end
          end else if (!en_s_r) begin
            state_nxt = S_OFF;
          end
        end
        // enable may drop inside the accept delay: the brake must still clamp before power goes
        S_RELEASE_WAIT, S_RUN: begin
          if (!en_s_r) begin
            if (!brake_assigned) begin
              state_nxt = S_OFF;
            end else if (moving) begin
              state_nxt = S_ROT_WAIT;
              tm.load = 1'b1;
              tm.load_ms = rot_dly_r;
            end else begin
              state_nxt = S_STATIC_HOLD;
              tm.load = 1'b1;
              tm.load_ms = static_dly_r;
            end
          end else if (state_r == S_RELEASE_WAIT && tm.done) begin
            state_nxt = S_RUN;
          end
        end
        S_STATIC_HOLD, S_ROT_WAIT, S_ROT_HOLD: begin
          if (en_s_r) begin
            // brake may be clamped again, so the accept delay starts over
            state_nxt = (accept_dly_r == 10'h000) ? S_RUN : S_RELEASE_WAIT;
            tm.load = 1'b1;
            tm.load_ms = accept_dly_r;
          end else if (state_r == S_ROT_WAIT) begin
            if (spd_s_r <= speed_lim_r || tm.done) begin
              state_nxt = S_ROT_HOLD;
              tm.load = 1'b1;
              tm.load_ms = ROT_HOLD_MS;
            end
          end else if (tm.done) begin
            state_nxt = S_OFF;
          end
        end
        default: state_nxt = S_OFF;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_r <= S_OFF;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs registered from the next state so they follow the state with no lag
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      brake_rel_r <= 1'b0;
      o_motor_energize <= 1'b0;
      o_instr_accept <= 1'b0;
    end else begin
      brake_rel_r <= state_nxt == S_RELEASE_WAIT || state_nxt == S_RUN ||
                     state_nxt == S_ROT_WAIT;
      o_motor_energize <= state_nxt != S_OFF && state_nxt != S_FAULT;
      o_instr_accept <= state_nxt == S_RUN;
    end
  end

  // unassigned outputs idle low; their other functions live elsewhere
  genvar g;
  generate
    for (g = 0; g < NUM_DO; g++) begin : g_do
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          o_brake_release_out[g] <= 1'b0;
        end else if (is_brake(act_func_r[8*g +: 8])) begin
          o_brake_release_out[g] <= (state_nxt == S_RELEASE_WAIT || state_nxt == S_RUN ||
                                     state_nxt == S_ROT_WAIT) ^ act_logic_r[g];
        end else begin
          o_brake_release_out[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // helper: cycles since brake release began
  logic [31:0] rel_cnt_r;
  always_ff @(posedge i_core_clk) begin
    if (i_rst || !brake_rel_r) begin
      rel_cnt_r <= 32'h0000_0000;
    end else if (rel_cnt_r != 32'hffff_ffff) begin
      rel_cnt_r <= rel_cnt_r + 32'h0000_0001;
    end
  end

  chk_fault_free_stop: assert property (@(posedge i_core_clk) disable iff (i_rst)
    fault_s_r |=> !o_motor_energize && !brake_rel_r && !o_instr_accept)
    else $error("fault did not give free stop");

  chk_unassigned_do_low: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !brake_assigned && $past(!brake_assigned) |-> o_brake_release_out == '0)
    else $error("brake level on unassigned output");

  chk_accept_after_delay: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(o_instr_accept) && brake_assigned && $stable(accept_dly_r)
      |-> rel_cnt_r >= 32'(accept_dly_r) * 32'(P_TICK_CYCLES))
    else $error("instructions accepted before delay");

  chk_static_stop: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == S_RUN || state_r == S_RELEASE_WAIT) && !en_s_r && !fault_s_r &&
      brake_assigned && !moving
      |=> !brake_rel_r && o_motor_energize ##1 o_motor_energize)
    else $error("static stop sequence wrong");

  chk_rot_sequence: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == S_RUN || state_r == S_RELEASE_WAIT) && !en_s_r && !fault_s_r &&
      brake_assigned && moving
      |=> brake_rel_r && o_motor_energize && state_r == S_ROT_WAIT)
    else $error("rotating stop not taken");

  chk_rot_release: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_r == S_ROT_WAIT && !en_s_r && !fault_s_r && (spd_s_r <= speed_lim_r || tm.done)
      |=> !brake_rel_r && state_r == S_ROT_HOLD)
    else $error("rotating brake release missed");

  chk_rot_hold_load: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_nxt == S_ROT_HOLD && state_r != S_ROT_HOLD |-> tm.load && tm.load_ms == ROT_HOLD_MS)
    else $error("rotating hold not 50 ms");

  chk_no_brake_direct: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_r == S_OFF && en_s_r && !fault_s_r && !brake_assigned |=> o_instr_accept)
    else $error("unassigned brake still delayed");

  chk_assign_on_apply: assert property (@(posedge i_core_clk) disable iff (i_rst)
    !apply_pulse |=> $stable(act_func_r) && $stable(act_logic_r))
    else $error("assignment changed without restart");

  chk_restart_on_enable: assert property (@(posedge i_core_clk) disable iff (i_rst)
    (state_r == S_STATIC_HOLD || state_r == S_ROT_HOLD) && en_s_r && !fault_s_r
      |-> tm.load && tm.load_ms == accept_dly_r ##1 brake_rel_r && o_motor_energize)
    else $error("sequence not restarted");

  cov_static_stop: cover property (@(posedge i_core_clk) disable iff (i_rst)
    state_r == S_STATIC_HOLD ##1 state_r == S_OFF);
  cov_rot_stop: cover property (@(posedge i_core_clk) disable iff (i_rst)
    state_r == S_ROT_HOLD ##1 state_r == S_OFF);
  cov_fault: cover property (@(posedge i_core_clk) disable iff (i_rst)
    state_r == S_RUN ##1 state_r == S_FAULT);
endmodule // brake_seq

// ==== core/brake_seq_pkg.sv ====
// constants for the holding-brake sequencer: register map, fields, resets, timing
// assumes a 200 MHz core clock and a 32-bit apb register bus
package brake_seq_pkg;
  localparam int unsigned CLK_FREQ_MHZ = 200;
  localparam int unsigned TICK_PERIOD_US = 1000;
  localparam int unsigned TICK_CYCLES = CLK_FREQ_MHZ * TICK_PERIOD_US;
  localparam int unsigned NUM_DO = 4;
  localparam logic [7:0] BRAKE_FUNC_CODE = 8'h8d;
  localparam logic [15:0] STATIC_SPEED_RPM = 16'h0014;
  localparam logic [9:0] ROT_HOLD_MS = 10'h032;
  // register byte offsets
  localparam logic [7:0] DO_FUNC_OFF = 8'h00;
  localparam logic [7:0] DO_LOGIC_OFF = 8'h04;
  localparam logic [7:0] ACCEPT_DLY_OFF = 8'h08;
  localparam logic [7:0] STATIC_DLY_OFF = 8'h0c;
  localparam logic [7:0] SPEED_LIM_OFF = 8'h10;
  localparam logic [7:0] ROT_DLY_OFF = 8'h14;
  localparam logic [7:0] APPLY_OFF = 8'h18;
  localparam logic [7:0] STATUS_OFF = 8'h1c;
  // reset values and ranges
  localparam logic [31:0] DO_FUNC_RST = 32'h0000_0000;
  localparam logic [3:0] DO_LOGIC_RST = 4'h0;
  localparam logic [9:0] ACCEPT_DLY_RST = 10'h0fa;
  localparam logic [9:0] ACCEPT_DLY_MAX = 10'h1f4;
  localparam logic [9:0] STATIC_DLY_RST = 10'h096;
  localparam logic [15:0] SPEED_LIM_RST = 16'h001e;
  localparam logic [15:0] SPEED_LIM_MAX = 16'h0bb8;
  localparam logic [9:0] ROT_DLY_RST = 10'h1f4;
  localparam logic [9:0] DLY_MIN = 10'h001;
  localparam logic [9:0] DLY_MAX = 10'h3e8;
  // status fields
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_ASSIGNED_BIT = 4;
  localparam int unsigned ST_ACCEPT_BIT = 5;
  localparam int unsigned ST_ENERGIZED_BIT = 6;
  localparam int unsigned ST_RELEASED_BIT = 7;
  localparam int unsigned ST_MOVING_BIT = 8;

  typedef enum logic [2:0] {
    S_OFF = 3'b000,
    S_RELEASE_WAIT = 3'b001,
    S_RUN = 3'b010,
    S_STATIC_HOLD = 3'b011,
    S_ROT_WAIT = 3'b100,
    S_ROT_HOLD = 3'b101,
    S_FAULT = 3'b110
  } seq_state_t;
endpackage

// ==== core/ms_timer_if.sv ====
// carrier between the sequencer and its millisecond timer
// assumes both ends run on the same core clock
`timescale 1ns/1ps
interface ms_timer_if;
  logic load;
  logic [9:0] load_ms;
  logic done;
  modport ctrl (output load, output load_ms, input done);
  modport tmr (input load, input load_ms, output done);
endinterface

// ==== core/ms_timer.sv ====
// millisecond countdown: prescaler gives a 1 ms enable, count reloads on demand
// assumes i_rst is synchronous and the load pulse comes from the same clock
`timescale 1ns/1ps
module ms_timer #(
  parameter int unsigned P_TICK_CYCLES = 200000
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  ms_timer_if.tmr tm
);
  logic [31:0] pre_r;
  logic [9:0] cnt_r;
  logic tick;

  assign tick = (pre_r == 32'(P_TICK_CYCLES - 1));
  assign tm.done = (cnt_r == 10'h000);

  // prescaler restarts on load so a delay is exactly n whole ticks
  always_ff @(posedge i_core_clk) begin
    if (i_rst || tm.load || tick) begin
      pre_r <= 32'h0000_0000;
    end else begin
      pre_r <= pre_r + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cnt_r <= 10'h000;
    end else if (tm.load) begin
      cnt_r <= tm.load_ms;
    end else if (tick && cnt_r != 10'h000) begin
      cnt_r <= cnt_r - 10'h001;
    end
  end
endmodule // ms_timer

// ==== verif/motion_partner.sv ====
// far-side model: motion controller issuing instructions and a decelerating motor
// assumes the same core clock as the sequencer and a synchronous active-high reset
`timescale 1ns/1ps
module motion_partner (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [15:0] i_set_rpm,
  input wire logic i_decel,
  input wire logic i_energized,
  input wire logic i_instr_accept,
  input wire logic i_instr_req,
  output logic [15:0] o_speed_rpm,
  output logic [15:0] o_instr_sent
);
  logic [15:0] speed_r;
  logic [15:0] sent_r;
  assign o_speed_rpm = speed_r;
  assign o_instr_sent = sent_r;
  // slows only under drive torque; the brake never stops a moving shaft
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      speed_r <= 16'h0000;
    end else if (i_load) begin
      speed_r <= i_set_rpm;
    end else if (i_decel && i_energized && speed_r != 16'h0000) begin
      speed_r <= speed_r - 16'h0001;
    end
  end
  // instructions held back until the drive says it takes them
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      sent_r <= 16'h0000;
    end else if (i_instr_req && i_instr_accept) begin
      sent_r <= sent_r + 16'h0001;
    end
  end
endmodule // motion_partner

// ==== verif/testbench.sv ====
// self-checking bench: apb register tasks and brake sequence scenarios
// assumes the tick parameter shrunk to 10 cycles per ms so all delays stay short
`timescale 1ns/1ps
module testbench;
  import brake_seq_pkg::*;
  localparam int P = 10;
  localparam int S = 6;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic en = 1'b0;
  logic flt = 1'b0;
  logic ld = 1'b0;
  logic dec = 1'b0;
  logic [15:0] set_spd = 16'h0000;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, energ, acc;
  logic [3:0] bro;
  logic [15:0] spd, sent, s0;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  logic [7:0] ra[4] = '{ACCEPT_DLY_OFF, STATIC_DLY_OFF, SPEED_LIM_OFF, ROT_DLY_OFF};
  logic [31:0] dv[4] = '{32'(ACCEPT_DLY_RST), 32'(STATIC_DLY_RST), 32'(SPEED_LIM_RST),
                         32'(ROT_DLY_RST)};
  logic [31:0] wv[4] = '{32'h0000_0258, 32'h0, 32'h0000_0fa0, 32'h0000_07d0};
  logic [31:0] cv[4] = '{32'(ACCEPT_DLY_MAX), 32'(DLY_MIN), 32'(SPEED_LIM_MAX), 32'(DLY_MAX)};

  always #2.5 clk = ~clk;

  brake_seq #(.P_TICK_CYCLES(P)) dut_u (
    .i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_servo_enable(en), .i_fault(flt), .i_motor_speed_rpm(spd),
    .o_brake_release_out(bro), .o_motor_energize(energ), .o_instr_accept(acc));

  motion_partner mp_u (
    .i_core_clk(clk), .i_rst(rst), .i_load(ld), .i_set_rpm(set_spd), .i_decel(dec),
    .i_energized(energ), .i_instr_accept(acc), .i_instr_req(en), .o_speed_rpm(spd),
    .o_instr_sent(sent));

  task automatic test_done();
    $display("checks %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask

  // entered just after a rising edge; pready and data taken at the same edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (k >= 50) begin
      chk(1'b0, "bus timeout");
      test_done();
    end
    @(posedge clk);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd === e && err === 1'b0, "register read mismatch");
  endtask

  function automatic logic pick(input int s);
    case (s)
      0: return bro[1];
      1: return energ;
      default: return acc;
    endcase
  endfunction

  // counts edges until the chosen output reaches v
  task automatic wait_sig(input int s, input logic v, output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (pick(s) !== v && c < 20000);
    if (c >= 20000) begin
      chk(1'b0, "wait timeout");
      test_done();
    end
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) rdchk(ra[i], dv[i]);
    rdchk(DO_FUNC_OFF, DO_FUNC_RST);
    apb(1'b0, 8'h20, 32'h0);
    chk(err === 1'b1 && rd === 32'h0, "unmapped access not refused");
    apb(1'b1, STATUS_OFF, 32'h0000_00ff);
    rdchk(STATUS_OFF, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, ra[i], wv[i]);
      rdchk(ra[i], cv[i]);
    end
    apb(1'b1, ACCEPT_DLY_OFF, 32'h5);
    apb(1'b1, STATIC_DLY_OFF, 32'h3);
    apb(1'b1, SPEED_LIM_OFF, 32'ha);
    // no brake output yet: delays must be skipped
    en <= 1'b1;
    wait_sig(2, 1'b1, n);
    chk(n <= S && bro === 4'h0, "accept delayed without brake");
    en <= 1'b0;
    wait_sig(1, 1'b0, n);
    chk(n <= S, "slow power off without brake");
    apb(1'b1, DO_FUNC_OFF, 32'h0000_8d00);
    en <= 1'b1;
    wait_sig(2, 1'b1, n);
    chk(n <= S && bro === 4'h0, "assignment applied before restart");
    en <= 1'b0;
    wait_sig(1, 1'b0, n);
    apb(1'b1, APPLY_OFF, 32'h1);
    rdchk(STATUS_OFF, 32'h0000_0010);
    en <= 1'b1;
    wait_sig(0, 1'b1, n);
    chk(n <= S && bro === 4'h2, "brake release wrong output");
    s0 = sent;
    wait_sig(2, 1'b1, n);
    chk(n >= 5 * P - 2 && n <= 5 * P + S, "accept delay");
    chk(sent === s0, "instruction taken in accept delay");
    // stationary stop at 19 rpm
    set_spd <= 16'h0013;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    en <= 1'b0;
    wait_sig(0, 1'b0, n);
    chk(n <= S && acc === 1'b0 && energ === 1'b1, "static brake off");
    wait_sig(1, 1'b0, n);
    chk(n >= 3 * P - 2 && n <= 3 * P + S, "static power off delay");
    // re-enable inside the static hold restarts the sequence
    en <= 1'b1;
    wait_sig(2, 1'b1, n);
    en <= 1'b0;
    wait_sig(0, 1'b0, n);
    repeat (10) @(posedge clk);
    en <= 1'b1;
    wait_sig(0, 1'b1, n);
    chk(n <= S && energ === 1'b1, "restart release");
    wait_sig(2, 1'b1, n);
    chk(n >= 5 * P - 2 && n <= 5 * P + S, "restart accept delay");
    // rotating stop exactly at 20 rpm, ends on the speed threshold
    set_spd <= 16'h0014;
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    repeat (4) @(posedge clk);
    en <= 1'b0;
    dec <= 1'b1;
    wait_sig(0, 1'b0, n);
    chk(n >= 10 && n <= 12 + 2 * S, "threshold brake off");
    wait_sig(1, 1'b0, n);
    chk(n >= int'(ROT_HOLD_MS) * P - 2 && n <= int'(ROT_HOLD_MS) * P + S,
        "rotating hold");
    // rotating stop that never slows: max delay decides
    dec <= 1'b0;
    set_spd <= 16'h0064;
    ld <= 1'b1;
    apb(1'b1, ROT_DLY_OFF, 32'h2);
    ld <= 1'b0;
    en <= 1'b1;
    wait_sig(2, 1'b1, n);
    en <= 1'b0;
    wait_sig(0, 1'b0, n);
    chk(n >= 2 * P - 2 && n <= 2 * P + S, "rotating max delay");
    wait_sig(1, 1'b0, n);
    chk(n >= int'(ROT_HOLD_MS) * P - 2, "rotating hold short");
    // fault while running fast: free stop, no brake sequence
    en <= 1'b1;
    wait_sig(2, 1'b1, n);
    flt <= 1'b1;
    wait_sig(1, 1'b0, n);
    chk(n <= S && bro === 4'h0 && acc === 1'b0, "fault not free stop");
    flt <= 1'b0;
    en <= 1'b0;
    repeat (5) @(posedge clk);
    // inverted polarity shows as high while the brake holds
    apb(1'b1, DO_LOGIC_OFF, 32'h2);
    apb(1'b1, APPLY_OFF, 32'h1);
    repeat (3) @(posedge clk);
    chk(bro === 4'h2, "output polarity");
    test_done();
  end
endmodule // testbench
